// ### pkg/ctu_regs.vh
// Constants of the charge/time unit control logic: control-register bit
// positions, reset values, channel numbers and timing counts.
// Assumes a 100 MHz system clock and inclusion by bare name.
`ifndef CTU_REGS_VH
`define CTU_REGS_VH

// ----------------------------------------------------------------------
// Main control register layout
// ----------------------------------------------------------------------
`define CTU_CTL_W 8
`define CTU_CTL_DISCHARGE_BIT 1
`define CTU_CTL_STOP_IDLE_BIT 5
`define CTU_CTL_ENABLE_BIT 7
`define CTU_CTL_RESET 8'h00

// ----------------------------------------------------------------------
// Edge status register layout
// ----------------------------------------------------------------------
`define CTU_EDGE_W 2
`define CTU_EDGE_ONE_BIT 0
`define CTU_EDGE_TWO_BIT 1
`define CTU_EDGE_RESET 2'h0

// ----------------------------------------------------------------------
// Channel multiplexer
// ----------------------------------------------------------------------
`define CTU_CHAN_W 5
`define CTU_CHAN_RESET 5'h00
`define CTU_CHAN_TEMP_DIODE 5'h1D

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CTU_CLK_PERIOD_NS 10
`define CTU_TIMER_W 16

`endif

// ### src/ctu_interval_timer.v
// Interval timer that counts clock cycles while the current source runs.
// Gives firmware a digital view of the charge time next to the A/D result.
// Assumes synchronous, active-high reset and one clock domain.
`timescale 1ns/100ps
`include "ctu_regs.vh"

module ctu_interval_timer (
  input wire clk,
  input wire srst,
  input wire clear,
  input wire run,
  output reg [`CTU_TIMER_W-1:0] count_q,
  output reg overflow_q
);

  // --------------------------------------------------------------------
  // Counter; saturates so a stuck charge never wraps to a small value
  // --------------------------------------------------------------------
  always @(posedge clk) begin
    if (srst || clear) begin
      count_q <= {`CTU_TIMER_W{1'b0}};
      overflow_q <= 1'b0;
    end else if (run) begin
      if (&count_q) begin
        overflow_q <= 1'b1;
      end else begin
        count_q <= count_q + {{(`CTU_TIMER_W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // ctu_interval_timer

// ### src/ctu_charge_control.v
// Control logic of the charge/time measurement unit: current-source
// gating, discharge, channel mux sharing with the A/D, low-power gating.
// Assumes firmware drives the control bits as plain ports and the A/D
// converter and analog switches sit outside, driven by these outputs.
//
// Operation
// - Edge one set charges selected channel
// - Discharge bit drains the measured circuit
// - Edge one starts, edge two stops charge
// - One channel mux for source and converter
// - Temperature diode on its own channel
// - Sleep forces current source off
// - Charge cut by sleep may be wrong
// - Stop-in-idle clear keeps unit running idle
// - Stop-in-idle set disables source in idle
// - Reset clears all unit registers
// - Discharge bit sits at control bit 1
`timescale 1ns/100ps
`include "ctu_regs.vh"

module ctu_charge_control (
  input wire clk,
  input wire srst,
  input wire ctl_we,
  input wire [`CTU_CTL_W-1:0] ctl_wdata,
  input wire edge_we,
  input wire [`CTU_EDGE_W-1:0] edge_wdata,
  input wire chan_we,
  input wire [`CTU_CHAN_W-1:0] chan_wdata,
  input wire sleep_mode,
  input wire idle_mode,
  input wire conversion_done_flag,
  output reg [`CTU_CTL_W-1:0] main_control_reg_q,
  output reg edge_one_status_q,
  output reg edge_two_status_q,
  output reg [`CTU_CHAN_W-1:0] mux_chan_q,
  output reg temp_diode_sel_q,
  output reg source_on_q,
  output reg discharge_on_q,
  output reg charge_aborted_q,
  output reg [1:0] phase_q,
  output reg [`CTU_TIMER_W-1:0] charge_cycles_q,
  output reg charge_overflow_q
);

  // --------------------------------------------------------------------
  // Phases reported to firmware
  // --------------------------------------------------------------------
  localparam PH_IDLE = 2'b00;
  localparam PH_DRAIN = 2'b01;
  localparam PH_CHARGE = 2'b10;
  localparam PH_HOLD = 2'b11;

  wire unit_enable;
  wire stop_in_idle;
  wire discharge_enable;
  wire power_block;
  wire source_d;
  wire discharge_d;
  wire new_charge;
  wire [`CTU_TIMER_W-1:0] timer_count;
  wire timer_overflow;
  reg [1:0] phase_d;

  assign unit_enable = main_control_reg_q[`CTU_CTL_ENABLE_BIT];
  assign stop_in_idle = main_control_reg_q[`CTU_CTL_STOP_IDLE_BIT];
  assign discharge_enable = main_control_reg_q[`CTU_CTL_DISCHARGE_BIT];

  // --------------------------------------------------------------------
  // Firmware-written registers
  // --------------------------------------------------------------------
  // Sleep always blocks; idle blocks only when stop-in-idle is set.
  assign power_block = sleep_mode | (idle_mode & stop_in_idle);

  always @(posedge clk) begin
    if (srst) begin
      main_control_reg_q <= `CTU_CTL_RESET;
      edge_one_status_q <= 1'b0;
      edge_two_status_q <= 1'b0;
      mux_chan_q <= `CTU_CHAN_RESET;
    end else begin
      if (ctl_we) begin
        main_control_reg_q <= ctl_wdata;
      end
      if (edge_we) begin
        edge_one_status_q <= edge_wdata[`CTU_EDGE_ONE_BIT];
        edge_two_status_q <= edge_wdata[`CTU_EDGE_TWO_BIT];
      end
      if (chan_we) begin
        mux_chan_q <= chan_wdata;
      end
    end
  end

  // --------------------------------------------------------------------
  // Analog switch controls
  // --------------------------------------------------------------------
  // Source and drain are never on together so the drain cannot fight it.
  assign source_d = unit_enable & edge_one_status_q & ~edge_two_status_q
                    & ~power_block & ~discharge_enable;
  assign discharge_d = unit_enable & discharge_enable;
  assign new_charge = source_d & ~source_on_q;

  always @(posedge clk) begin
    if (srst) begin
      source_on_q <= 1'b0;
      discharge_on_q <= 1'b0;
      temp_diode_sel_q <= 1'b0;
      charge_aborted_q <= 1'b0;
    end else begin
      source_on_q <= source_d;
      discharge_on_q <= discharge_d;
      // Same mux code feeds source and converter; diode is a normal code
      temp_diode_sel_q <= (mux_chan_q == `CTU_CHAN_TEMP_DIODE);
      // Result of a charge cut by a low-power mode is flagged as suspect
      if (new_charge) begin
        charge_aborted_q <= 1'b0;
      end else if (source_on_q && power_block) begin
        charge_aborted_q <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------
  // Phase tracking
  // --------------------------------------------------------------------
  always @* begin
    phase_d = phase_q;
    case (phase_q)
      PH_IDLE: begin
        if (discharge_d) begin
          phase_d = PH_DRAIN;
        end else if (source_d) begin
          phase_d = PH_CHARGE;
        end
      end
      PH_DRAIN: begin
        if (!discharge_d) begin
          phase_d = source_d ? PH_CHARGE : PH_IDLE;
        end
      end
      PH_CHARGE: begin
        if (discharge_d) begin
          phase_d = PH_DRAIN;
        end else if (!source_d) begin
          phase_d = PH_HOLD;
        end
      end
      PH_HOLD: begin
        // Held voltage stays until converted, drained or charged again
        if (discharge_d) begin
          phase_d = PH_DRAIN;
        end else if (source_d) begin
          phase_d = PH_CHARGE;
        end else if (conversion_done_flag) begin
          phase_d = PH_IDLE;
        end
      end
      default: begin
        phase_d = PH_IDLE;
      end
    endcase
    if (!unit_enable) begin
      phase_d = PH_IDLE;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      phase_q <= PH_IDLE;
      charge_cycles_q <= {`CTU_TIMER_W{1'b0}};
      charge_overflow_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      charge_cycles_q <= timer_count;
      charge_overflow_q <= timer_overflow;
    end
  end

  // --------------------------------------------------------------------
  // Charge interval counter, restarted on each new charge
  // --------------------------------------------------------------------
  ctu_interval_timer u_timer (
    .clk(clk),
    .srst(srst),
    .clear(new_charge | discharge_d),
    .run(source_on_q),
    .count_q(timer_count),
    .overflow_q(timer_overflow)
  );

endmodule // ctu_charge_control

// ### test/ctu_charge_control_props.sv
// Port checker for the charge/time control block.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
module ctu_charge_props (
  input wire clk, srst, ctl_we, edge_we, chan_we, sleep_mode, idle_mode,
  input wire conversion_done_flag, edge_one_status_q, edge_two_status_q,
  input wire temp_diode_sel_q, source_on_q, discharge_on_q, charge_aborted_q,
  input wire charge_overflow_q,
  input wire [7:0] ctl_wdata, main_control_reg_q,
  input wire [1:0] edge_wdata, phase_q,
  input wire [4:0] chan_wdata, mux_chan_q,
  input wire [15:0] charge_cycles_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_ready;
    main_control_reg_q[7] && edge_one_status_q && !edge_two_status_q &&
      !main_control_reg_q[1] && !sleep_mode && !idle_mode;
  endsequence
  sequence s_sleep;
    sleep_mode [*2];
  endsequence
  property p_ena; !main_control_reg_q[7] |=> !source_on_q; endproperty
  property p_charge; s_ready [*2] |=> source_on_q; endproperty
  property p_edge2; edge_two_status_q |=> !source_on_q; endproperty
  property p_drain;
    main_control_reg_q[7] && main_control_reg_q[1] |=> discharge_on_q && !source_on_q;
  endproperty
  property p_undrain; !main_control_reg_q[1] |=> !discharge_on_q; endproperty
  property p_sleep; s_sleep |=> !source_on_q; endproperty
  property p_abort; source_on_q && sleep_mode |=> charge_aborted_q; endproperty
  property p_idle; (idle_mode && main_control_reg_q[5]) [*2] |=> !source_on_q; endproperty
  property p_chan; chan_we |=> mux_chan_q == $past(chan_wdata); endproperty
  property p_temp;
    !$past(srst) |-> temp_diode_sel_q == ($past(mux_chan_q) == 5'h1D);
  endproperty
  property p_reset;
    disable iff (1'b0) srst |=> !source_on_q && !discharge_on_q &&
      main_control_reg_q == 8'h00 && phase_q == 2'h0;
  endproperty
  a_ena: assert property (p_ena) else $error("source on while unit disabled");
  a_charge: assert property (p_charge) else $error("source not on");
  a_edge2: assert property (p_edge2) else $error("second edge left source on");
  a_drain: assert property (p_drain) else $error("drain not applied");
  a_undrain: assert property (p_undrain) else $error("drain left on");
  a_sleep: assert property (p_sleep) else $error("source on in sleep");
  a_abort: assert property (p_abort) else $error("cut charge not flagged");
  a_idle: assert property (p_idle) else $error("source on in stopped idle");
  a_chan: assert property (p_chan) else $error("channel not taken");
  a_temp: assert property (p_temp) else $error("diode select wrong");
  a_reset: assert property (p_reset) else $error("reset did not clear");
endmodule // ctu_charge_props
bind ctu_charge_control ctu_charge_props ctu_charge_props_i (
  .clk(clk), .srst(srst), .ctl_we(ctl_we), .edge_we(edge_we), .chan_we(chan_we),
  .sleep_mode(sleep_mode), .idle_mode(idle_mode),
  .conversion_done_flag(conversion_done_flag), .edge_one_status_q(edge_one_status_q),
  .edge_two_status_q(edge_two_status_q), .temp_diode_sel_q(temp_diode_sel_q),
  .source_on_q(source_on_q), .discharge_on_q(discharge_on_q),
  .charge_aborted_q(charge_aborted_q), .charge_overflow_q(charge_overflow_q),
  .ctl_wdata(ctl_wdata), .main_control_reg_q(main_control_reg_q),
  .edge_wdata(edge_wdata), .phase_q(phase_q), .chan_wdata(chan_wdata),
  .mux_chan_q(mux_chan_q), .charge_cycles_q(charge_cycles_q)
);

// ### test/ctu_adc_model.sv
// Stand-in for the A/D converter: answers a hold phase with a done flag.
// Assumes phase code 3 means the charge is held for conversion.
`timescale 1ns/100ps
module ctu_adc_model #(parameter int LAT = 3) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [1:0] phase_q,
  output logic conversion_done_flag
);
  int cnt;
  // Conversion only after charging has stopped
  always @(posedge clk) begin
    if (srst || phase_q != 2'h3) begin
      cnt <= 0;
      conversion_done_flag <= 1'b0;
    end else begin
      cnt <= cnt + 1;
      conversion_done_flag <= (cnt == LAT);
    end
  end
endmodule // ctu_adc_model

// ### test/charge_time_measure_control_tb.sv
// Self-checking bench for the charge/time control logic.
// Assumes the A/D stand-in model and the bound port checker.
`timescale 1ns/100ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin mismatches++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module charge_time_measure_control_tb;
  logic clk = 0, srst = 1, ctl_we = 0, edge_we = 0, chan_we = 0;
  logic sleep_mode = 0, idle_mode = 0;
  logic [7:0] ctl_wdata = 8'h00, main_control_reg_q;
  logic [1:0] edge_wdata = 2'h0, phase_q;
  logic [4:0] chan_wdata = 5'h00, mux_chan_q;
  logic [15:0] charge_cycles_q;
  logic conversion_done_flag, edge_one_status_q, edge_two_status_q, temp_diode_sel_q;
  logic source_on_q, discharge_on_q, charge_aborted_q, charge_overflow_q;
  int mismatches = 0, check_count = 0;
  // Row: control, edges, {sleep, idle, expected source, expected drain}
  logic [13:0] rows [9] = '{{8'h80, 2'h1, 4'h2}, {8'h00, 2'h1, 4'h0},
    {8'h80, 2'h3, 4'h0}, {8'h82, 2'h0, 4'h1}, {8'h82, 2'h1, 4'h1},
    {8'h80, 2'h1, 4'h8}, {8'h80, 2'h1, 4'h6}, {8'hA0, 2'h1, 4'h4},
    {8'hA0, 2'h1, 4'h2}};
  always #5 clk = ~clk;
  ctu_charge_control ctu_charge_control_i (
    .clk(clk), .srst(srst), .ctl_we(ctl_we), .ctl_wdata(ctl_wdata),
    .edge_we(edge_we), .edge_wdata(edge_wdata), .chan_we(chan_we),
    .chan_wdata(chan_wdata), .sleep_mode(sleep_mode), .idle_mode(idle_mode),
    .conversion_done_flag(conversion_done_flag), .main_control_reg_q(main_control_reg_q),
    .edge_one_status_q(edge_one_status_q), .edge_two_status_q(edge_two_status_q),
    .mux_chan_q(mux_chan_q), .temp_diode_sel_q(temp_diode_sel_q),
    .source_on_q(source_on_q), .discharge_on_q(discharge_on_q),
    .charge_aborted_q(charge_aborted_q), .phase_q(phase_q),
    .charge_cycles_q(charge_cycles_q), .charge_overflow_q(charge_overflow_q)
  );
  ctu_adc_model ctu_adc_model_i (.clk(clk), .srst(srst), .phase_q(phase_q),
    .conversion_done_flag(conversion_done_flag));
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(logic [7:0] c, logic [1:0] e);
    @(negedge clk);
    ctl_we = 1;
    ctl_wdata = c;
    edge_we = 1;
    edge_wdata = e;
    @(negedge clk);
    ctl_we = 0;
    edge_we = 0;
  endtask
  task automatic conclude;
    $display("Checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Generous bound: the sequence needs well under 1000 cycles
  initial begin
    #50000;
    mismatches++;
    conclude();
  end
  initial begin
    cyc(6);
    srst = 0;
    `CHK(main_control_reg_q, 8'h00)
    foreach (rows[i]) begin
      sleep_mode = rows[i][3];
      idle_mode = rows[i][2];
      wr(rows[i][13:6], rows[i][5:4]);
      cyc(3);
      `CHK(source_on_q, rows[i][1])
      `CHK(discharge_on_q, rows[i][0])
      sleep_mode = 0;
      idle_mode = 0;
      wr(8'h00, 2'h0);
      cyc(2);
    end
    // Time walk: first edge starts, second edge stops, converter ends hold
    // Short interval: an unused channel keeps stray capacitance low
    chan_we = 1;
    chan_wdata = 5'h14;
    cyc(1);
    chan_we = 0;
    wr(8'h80, 2'h1);
    cyc(6);
    wr(8'h80, 2'h3);
    cyc(2);
    `CHK(phase_q, 2'h3)
    `CHK({edge_one_status_q, edge_two_status_q}, 2'h3)
    `CHK(charge_cycles_q, 16'h0008)
    `CHK(charge_overflow_q, 1'b0)
    `CHK(mux_chan_q, 5'h14)
    `CHK(temp_diode_sel_q, 1'b0)
    repeat (20) if (phase_q != 2'h0) cyc(1);
    `CHK(phase_q, 2'h0)
    // Sleep in mid-charge cuts it and flags the result
    wr(8'h80, 2'h1);
    cyc(4);
    sleep_mode = 1;
    cyc(3);
    `CHK(source_on_q, 1'b0)
    `CHK(charge_aborted_q, 1'b1)
    sleep_mode = 0;
    chan_we = 1;
    chan_wdata = 5'h1D;
    cyc(1);
    chan_we = 0;
    cyc(2);
    `CHK(mux_chan_q, 5'h1D)
    `CHK(temp_diode_sel_q, 1'b1)
    srst = 1;
    cyc(1);
    srst = 0;
    `CHK({main_control_reg_q, mux_chan_q, source_on_q}, 14'h0000)
    cyc(2);
    `CHK({temp_diode_sel_q, charge_aborted_q, discharge_on_q, phase_q}, 5'h00)
    `CHK(charge_cycles_q, 16'h0000)
    conclude();
  end
endmodule // charge_time_measure_control_tb
